//--- smr_pkg.sv
package smr_pkg;

    // Register map, byte addresses on the AXI4-Lite slave
    localparam logic [7:0] SMR_OFS_BRK_EXIT  = 8'h00;
    localparam logic [7:0] SMR_OFS_RST_CAUSE = 8'h04;
    localparam logic [7:0] SMR_OFS_BRK_CLR   = 8'h08;
    localparam logic [7:0] SMR_ADDR_WORD_MSK = 8'hFC;
    localparam int         SMR_ADDR_W        = 8;
    localparam int         SMR_DATA_W        = 32;

    // Field positions
    localparam int SMR_BIT_BRK_EXIT  = 0;
    localparam int SMR_BIT_CLR_EN    = 0;
    localparam int SMR_RC_W          = 6;
    localparam int SMR_RC_UV         = 0;
    localparam int SMR_RC_BADFETCH   = 1;
    localparam int SMR_RC_BADOP      = 2;
    localparam int SMR_RC_WDOG       = 3;
    localparam int SMR_RC_PIN        = 4;
    localparam int SMR_RC_POR        = 5;

    // Reset values
    localparam logic [SMR_RC_W-1:0] SMR_RC_POR_VAL = 6'h20;
    localparam logic                SMR_CLR_EN_RST = 1'h0;

    // Bus answers
    localparam logic [1:0] SMR_RESP_OKAY   = 2'h0;
    localparam logic [1:0] SMR_RESP_SLVERR = 2'h2;

    // Recovery timing, in crystal clock cycles
    localparam int SMR_CNT_W         = 12;
    localparam int SMR_LONG_REC_CYC  = 4096;
    localparam int SMR_SHORT_REC_CYC = 32;

    typedef enum logic [1:0] {
        SMR_RUN,
        SMR_HALT,
        SMR_RECOVER,
        SMR_RESUME
    } smr_state_e;

endpackage : smr_pkg

//--- smr_top.sv
// What this block does
// - Halt entry clears counter, stops system clocks
// - Interrupt, reset or break ends halt mode
// - No interrupt stacking before recovery delay ends
// - Halt disables bus and crystal clock outputs
// - Recovery 4096 cycles, or 32 when short
// - Break exiting halt or idle sets flag
// - Counter held cleared until recovery, then counts
// - Writing zero or any reset clears flag
// - Exactly three registers are mapped
// - Six reset cause flags, cleared by read
// - Power-on sets its flag, clears others
// - Reset pin sets external reset flag
// - Watchdog reset sets watchdog flag
// - Illegal opcode reset sets its flag
// - Illegal fetch address reset sets its flag
// - Undervoltage reset sets its flag
// - Break state clearing in other modules allowed only when enabled
// - Twelve bit counter on falling clock edge
// - Two-step clears stay protected during break
// - Flags cleared in break stay cleared
//
// Chosen here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module smr_top
    import smr_pkg::*;
#(
    parameter int LONG_REC  = SMR_LONG_REC_CYC,
    parameter int SHORT_REC = SMR_SHORT_REC_CYC
)(
    input  wire logic                  CLK,
    input  wire logic                  RST_B,
    input  wire logic [SMR_ADDR_W-1:0] AWADDR,
    input  wire logic                  AWVALID,
    output logic                       AWREADY,
    input  wire logic [SMR_DATA_W-1:0] WDATA,
    input  wire logic [3:0]            WSTRB,
    input  wire logic                  WVALID,
    output logic                       WREADY,
    output logic [1:0]                 BRESP,
    output logic                       BVALID,
    input  wire logic                  BREADY,
    input  wire logic [SMR_ADDR_W-1:0] ARADDR,
    input  wire logic                  ARVALID,
    output logic                       ARREADY,
    output logic [SMR_DATA_W-1:0]      RDATA,
    output logic [1:0]                 RRESP,
    output logic                       RVALID,
    input  wire logic                  RREADY,
    input  wire logic                  STOP_REQ,
    input  wire logic                  WAIT_ACTIVE,
    input  wire logic                  MOD_IRQ,
    input  wire logic                  BREAK_REQ,
    input  wire logic                  BREAK_STATE,
    input  wire logic                  SHORT_RECOVERY_SELECT,
    input  wire logic                  RESET_PIN_B,
    input  wire logic                  WDOG_RESET,
    input  wire logic                  BAD_OPCODE_RESET,
    input  wire logic                  BAD_FETCH_RESET,
    input  wire logic                  UNDERVOLT_RESET,
    output logic                       BUS_CLOCK_OUTPUT_EN,
    output logic                       CRYSTAL_CLOCK_OUTPUT_EN,
    output logic                       EXC_START,
    output logic                       HALTED,
    output logic                       STATUS_CLEAR_OK
);

    if (LONG_REC > 2 ** SMR_CNT_W || SHORT_REC < 2 || SHORT_REC > LONG_REC) begin : g_bad_rec
        $error("smr_top: recovery counts out of range for the counter");
    end

    localparam logic [SMR_CNT_W-1:0] LONG_LIM  = SMR_CNT_W'(LONG_REC - 1);
    localparam logic [SMR_CNT_W-1:0] SHORT_LIM = SMR_CNT_W'(SHORT_REC - 1);

    smr_state_e                  st_r;
    smr_state_e                  st_nxt;
    logic [SMR_CNT_W-1:0]        cnt_r;
    logic [SMR_CNT_W-1:0]        rec_cyc_r;
    logic                        short_r;
    logic                        cnt_done;
    logic                        wake;
    logic [1:0]                  pin_sync_r;
    logic                        pin_low_r;
    logic                        pin_evt;
    logic [SMR_RC_W-1:0]         cause_vec;
    logic                        sys_rst_evt;
    logic [SMR_RC_W-1:0]         rc_r;
    logic                        brk_flag_r;
    logic                        clr_en_r;
    logic                        brk_set;
    logic                        brk_wr0;
    logic                        aw_have_r;
    logic                        w_have_r;
    logic [SMR_ADDR_W-1:0]       aw_addr_r;
    logic [SMR_DATA_W-1:0]       w_data_r;
    logic [3:0]                  w_strb_r;
    logic                        wr_do;
    logic [SMR_ADDR_W-1:0]       wr_word;
    logic [SMR_ADDR_W-1:0]       rd_word;
    logic                        rd_hs;
    logic                        rc_rd_clr;
    logic                        awready_r;
    logic                        wready_r;
    logic                        bvalid_r;
    logic [1:0]                  bresp_r;
    logic                        arready_r;
    logic                        rvalid_r;
    logic [SMR_DATA_W-1:0]       rdata_r;
    logic [1:0]                  rresp_r;
    logic                        bus_en_r;
    logic                        xtal_en_r;
    logic                        exc_start_r;
    logic                        halted_r;
    logic                        clr_ok_r;

    // Reset pin synchroniser and falling edge
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            pin_sync_r <= 2'h3;
            pin_low_r  <= 1'h0;
        end else begin
            pin_sync_r <= {pin_sync_r[0], RESET_PIN_B};
            pin_low_r  <= !pin_sync_r[1];
        end
    end

    assign pin_evt = !pin_sync_r[1] && !pin_low_r;

    always_comb begin
        cause_vec                  = '0;
        cause_vec[SMR_RC_PIN]      = pin_evt;
        cause_vec[SMR_RC_WDOG]     = WDOG_RESET;
        cause_vec[SMR_RC_BADOP]    = BAD_OPCODE_RESET;
        cause_vec[SMR_RC_BADFETCH] = BAD_FETCH_RESET;
        cause_vec[SMR_RC_UV]       = UNDERVOLT_RESET;
    end

    assign sys_rst_evt = |cause_vec;
    assign wake        = MOD_IRQ || BREAK_REQ || sys_rst_evt;
    assign cnt_done    = cnt_r == (short_r ? SHORT_LIM : LONG_LIM);

    // Halt state machine
    always_comb begin
        st_nxt = st_r;
        unique case (st_r)
            SMR_RUN: begin
                if (STOP_REQ && !sys_rst_evt) begin
                    st_nxt = SMR_HALT;
                end
            end
            SMR_HALT: begin
                if (wake) begin
                    st_nxt = SMR_RECOVER;
                end
            end
            SMR_RECOVER: begin
                if (cnt_done) begin
                    st_nxt = SMR_RESUME;
                end
            end
            SMR_RESUME: begin
                st_nxt = SMR_RUN;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r <= SMR_RUN;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Recovery length option sampled at wake
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            short_r <= 1'h0;
        end else if (st_r == SMR_HALT && wake) begin
            short_r <= SHORT_RECOVERY_SELECT;
        end
    end

    // Recovery counter on the falling edge
    always_ff @(negedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            cnt_r <= '0;
        end else if (st_r != SMR_RECOVER) begin
            cnt_r <= '0;
        end else if (!cnt_done) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // Clock gating and CPU start
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bus_en_r    <= 1'h1;
            xtal_en_r   <= 1'h1;
            exc_start_r <= 1'h0;
            halted_r    <= 1'h0;
        end else begin
            bus_en_r    <= st_nxt == SMR_RUN || st_nxt == SMR_RESUME;
            xtal_en_r   <= st_nxt != SMR_HALT;
            exc_start_r <= st_r == SMR_RESUME;
            halted_r    <= st_nxt == SMR_HALT;
        end
    end

    // Break exit flag
    assign brk_set = BREAK_REQ && (st_r == SMR_HALT || WAIT_ACTIVE);
    assign brk_wr0 = wr_do && wr_word == SMR_OFS_BRK_EXIT && w_strb_r[0] && !w_data_r[SMR_BIT_BRK_EXIT];

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            brk_flag_r <= 1'h0;
        end else if (brk_set) begin
            brk_flag_r <= 1'h1;
        end else if (brk_wr0 || sys_rst_evt) begin
            brk_flag_r <= 1'h0;
        end
    end

    // Reset cause flags
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rc_r <= SMR_RC_POR_VAL;
        end else if (sys_rst_evt) begin
            rc_r <= cause_vec;
        end else if (rc_rd_clr) begin
            rc_r <= '0;
        end
    end

    // Break clear control
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            clr_en_r <= SMR_CLR_EN_RST;
        end else if (wr_do && wr_word == SMR_OFS_BRK_CLR && w_strb_r[0]) begin
            clr_en_r <= w_data_r[SMR_BIT_CLR_EN];
        end
    end

    // Clear permission for other modules, no memory of earlier steps
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            clr_ok_r <= 1'h1;
        end else begin
            clr_ok_r <= !BREAK_STATE || clr_en_r;
        end
    end

    // AXI4-Lite write path
    assign wr_do   = aw_have_r && w_have_r && !bvalid_r;
    assign wr_word = aw_addr_r & SMR_ADDR_WORD_MSK;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_have_r <= 1'h0;
            aw_addr_r <= '0;
            awready_r <= 1'h1;
        end else if (AWVALID && awready_r) begin
            aw_have_r <= 1'h1;
            aw_addr_r <= AWADDR;
            awready_r <= 1'h0;
        end else if (wr_do) begin
            aw_have_r <= 1'h0;
        end else if (bvalid_r && BREADY) begin
            awready_r <= 1'h1;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            w_have_r <= 1'h0;
            w_data_r <= '0;
            w_strb_r <= '0;
            wready_r <= 1'h1;
        end else if (WVALID && wready_r) begin
            w_have_r <= 1'h1;
            w_data_r <= WDATA;
            w_strb_r <= WSTRB;
            wready_r <= 1'h0;
        end else if (wr_do) begin
            w_have_r <= 1'h0;
        end else if (bvalid_r && BREADY) begin
            wready_r <= 1'h1;
        end
    end

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            bvalid_r <= 1'h0;
            bresp_r  <= SMR_RESP_OKAY;
        end else if (wr_do) begin
            bvalid_r <= 1'h1;
            if (wr_word == SMR_OFS_BRK_EXIT || wr_word == SMR_OFS_RST_CAUSE || wr_word == SMR_OFS_BRK_CLR) begin
                bresp_r <= SMR_RESP_OKAY;
            end else begin
                bresp_r <= SMR_RESP_SLVERR;
            end
        end else if (bvalid_r && BREADY) begin
            bvalid_r <= 1'h0;
        end
    end

    // AXI4-Lite read path
    assign rd_hs     = ARVALID && arready_r;
    assign rd_word   = ARADDR & SMR_ADDR_WORD_MSK;
    assign rc_rd_clr = rd_hs && rd_word == SMR_OFS_RST_CAUSE;

    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            arready_r <= 1'h1;
            rvalid_r  <= 1'h0;
            rdata_r   <= '0;
            rresp_r   <= SMR_RESP_OKAY;
        end else if (rd_hs) begin
            arready_r <= 1'h0;
            rvalid_r  <= 1'h1;
            rdata_r   <= '0;
            rresp_r   <= SMR_RESP_OKAY;
            unique case (rd_word)
                SMR_OFS_BRK_EXIT:  rdata_r[SMR_BIT_BRK_EXIT] <= brk_flag_r;
                SMR_OFS_RST_CAUSE: rdata_r[SMR_RC_W-1:0]     <= rc_r;
                SMR_OFS_BRK_CLR:   rdata_r[SMR_BIT_CLR_EN]   <= clr_en_r;
                default:           rresp_r                   <= SMR_RESP_SLVERR;
            endcase
        end else if (rvalid_r && RREADY) begin
            arready_r <= 1'h1;
            rvalid_r  <= 1'h0;
        end
    end

    // Recovery cycle count for checking
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rec_cyc_r <= '0;
        end else if (st_r != SMR_RECOVER) begin
            rec_cyc_r <= '0;
        end else begin
            rec_cyc_r <= rec_cyc_r + 1'b1;
        end
    end

    assign AWREADY                 = awready_r;
    assign WREADY                  = wready_r;
    assign BVALID                  = bvalid_r;
    assign BRESP                   = bresp_r;
    assign ARREADY                 = arready_r;
    assign RVALID                  = rvalid_r;
    assign RDATA                   = rdata_r;
    assign RRESP                   = rresp_r;
    assign BUS_CLOCK_OUTPUT_EN     = bus_en_r;
    assign CRYSTAL_CLOCK_OUTPUT_EN = xtal_en_r;
    assign EXC_START               = exc_start_r;
    assign HALTED                  = halted_r;
    assign STATUS_CLEAR_OK         = clr_ok_r;

    // Checks
    stop_entry_a: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r == SMR_RUN && STOP_REQ && !sys_rst_evt |=> st_r == SMR_HALT && !BUS_CLOCK_OUTPUT_EN)
        else $error("halt not entered after stop request");
    halt_wake_a: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r == SMR_HALT && (MOD_IRQ || BREAK_REQ || sys_rst_evt) |=> st_r == SMR_RECOVER)
        else $error("halt not left on wake event");
    halt_clocks_a: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r == SMR_HALT |-> !BUS_CLOCK_OUTPUT_EN && !CRYSTAL_CLOCK_OUTPUT_EN)
        else $error("clock output enabled during halt");
    recover_len_a: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r == SMR_RESUME |-> $past(rec_cyc_r) == (short_r ? SHORT_LIM : LONG_LIM) - 1'b1)
        else $error("recovery length differs from selected delay");
    early_start_a: assert property (@(posedge CLK) disable iff (!RST_B)
        EXC_START |-> $past(st_r) == SMR_RESUME && $past(st_r, 2) == SMR_RECOVER)
        else $error("processing started before recovery finished");
    bus_first_a: assert property (@(posedge CLK) disable iff (!RST_B)
        $rose(EXC_START) |-> BUS_CLOCK_OUTPUT_EN && $past(BUS_CLOCK_OUTPUT_EN))
        else $error("CPU started before bus clock returned");
    cnt_held_a: assert property (@(posedge CLK) disable iff (!RST_B)
        st_r != SMR_RECOVER && $past(st_r) != SMR_RECOVER |-> cnt_r == '0)
        else $error("recovery counter not held cleared");
    brk_flag_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
        BREAK_REQ && (st_r == SMR_HALT || WAIT_ACTIVE) |=> brk_flag_r)
        else $error("break exit flag not set");
    brk_flag_clr_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (brk_wr0 || sys_rst_evt) && !brk_set |=> !brk_flag_r)
        else $error("break exit flag not cleared");
    cause_read_a: assert property (@(posedge CLK) disable iff (!RST_B)
        rc_rd_clr && !sys_rst_evt |=> rc_r == '0 && RVALID)
        else $error("reset cause not cleared by read");
    cause_latch_a: assert property (@(posedge CLK) disable iff (!RST_B)
        sys_rst_evt |=> rc_r == $past(cause_vec) && !rc_r[SMR_RC_POR])
        else $error("reset cause not latched");
    wdog_cause_a: assert property (@(posedge CLK) disable iff (!RST_B)
        WDOG_RESET |=> rc_r[SMR_RC_WDOG])
        else $error("watchdog cause flag missing");
    clear_guard_a: assert property (@(posedge CLK) disable iff (!RST_B)
        BREAK_STATE && !clr_en_r |=> !STATUS_CLEAR_OK)
        else $error("clearing allowed in protected break state");

endmodule : smr_top

//--- smr_cpu_model.sv
`timescale 1ns/1ns
module smr_cpu_model (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic stop_cmd,
    input  wire logic irq_cmd,
    input  wire logic brk_cmd,
    input  wire logic canned_osc,
    input  wire logic wait_active,
    input  wire logic exc_start,
    output logic      stop_req,
    output logic      mod_irq,
    output logic      break_req,
    output logic      short_sel
);
    // Option bit stays clear unless a canned oscillator is modelled
    assign short_sel = canned_osc;

    // Stop instruction gives a one-cycle request
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stop_req <= 1'b0;
        end else begin
            stop_req <= stop_cmd;
        end
    end

    // Wake requests hold until the core starts processing, and drop while wait is active
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mod_irq   <= 1'b0;
            break_req <= 1'b0;
        end else begin
            mod_irq   <= irq_cmd | (mod_irq & ~exc_start & ~wait_active);
            break_req <= brk_cmd | (break_req & ~exc_start & ~wait_active);
        end
    end
endmodule : smr_cpu_model

//--- smr_top_tb_top.sv
`timescale 1ns/1ns
module smr_top_tb_top;
    import smr_pkg::*;
    localparam int LREC = 16;
    localparam int SREC = 4;
    logic        CLK, RST_B, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY, BVALID;
    logic        ARREADY, RVALID, STOP_REQ, WAIT_ACTIVE, MOD_IRQ, BREAK_REQ, BREAK_STATE, SHORT_SEL;
    logic        RESET_PIN_B, BUS_EN, XTAL_EN, EXC_START, HALTED, CLR_OK;
    logic        stop_cmd, irq_cmd, brk_cmd, canned;
    logic [7:0]  AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA;
    logic [3:0]  WSTRB, evt;
    logic [1:0]  BRESP, RRESP;
    int          n_mismatch, comparisons;

    smr_top #(.LONG_REC(LREC), .SHORT_REC(SREC)) uut (
        .CLK(CLK), .RST_B(RST_B), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
        .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
        .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
        .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .STOP_REQ(STOP_REQ),
        .WAIT_ACTIVE(WAIT_ACTIVE), .MOD_IRQ(MOD_IRQ), .BREAK_REQ(BREAK_REQ), .BREAK_STATE(BREAK_STATE),
        .SHORT_RECOVERY_SELECT(SHORT_SEL), .RESET_PIN_B(RESET_PIN_B), .WDOG_RESET(evt[3]),
        .BAD_OPCODE_RESET(evt[2]), .BAD_FETCH_RESET(evt[1]), .UNDERVOLT_RESET(evt[0]),
        .BUS_CLOCK_OUTPUT_EN(BUS_EN), .CRYSTAL_CLOCK_OUTPUT_EN(XTAL_EN), .EXC_START(EXC_START),
        .HALTED(HALTED), .STATUS_CLEAR_OK(CLR_OK)
    );

    smr_cpu_model cpu (
        .clk(CLK), .rst_b(RST_B), .stop_cmd(stop_cmd), .irq_cmd(irq_cmd), .brk_cmd(brk_cmd),
        .canned_osc(canned), .wait_active(WAIT_ACTIVE), .exc_start(EXC_START), .stop_req(STOP_REQ),
        .mod_irq(MOD_IRQ), .break_req(BREAK_REQ), .short_sel(SHORT_SEL)
    );

    task automatic finish_test;
        $display("TB: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic timeout(input string what);
        n_mismatch++;
        $display("unexpected timeout: %s", what);
        finish_test();
    endtask : timeout

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        AWADDR  <= a;
        WDATA   <= d;
        AWVALID <= 1'b1;
        WVALID  <= 1'b1;
        BREADY  <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
            if (AWVALID && AWREADY) AWVALID <= 1'b0;
            if (WVALID && WREADY) WVALID <= 1'b0;
        end while (!(BVALID && BREADY) && n < 50);
        if (n >= 50) timeout("write");
        check("bresp", 32'(BRESP), 32'(er));
        BREADY <= 1'b0;
        @(posedge CLK);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string what);
        int n;
        n = 0;
        ARADDR  <= a;
        ARVALID <= 1'b1;
        RREADY  <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
            if (ARVALID && ARREADY) ARVALID <= 1'b0;
        end while (!(RVALID && RREADY) && n < 50);
        if (n >= 50) timeout(what);
        check(what, RDATA, ed);
        check("rresp", 32'(RRESP), 32'(er));
        RREADY <= 1'b0;
        @(posedge CLK);
    endtask : rd

    // Mode 0 wakes by interrupt, 1 by break, 2 by a watchdog reset event
    task automatic halt_wake(input int mode, input logic shrt, input int len);
        int n, bus_at, exc_at;
        canned   <= shrt;
        stop_cmd <= 1'b1;
        @(posedge CLK);
        stop_cmd <= 1'b0;
        for (n = 0; n < 20 && HALTED !== 1'b1; n++) @(posedge CLK);
        if (n >= 20) timeout("halt");
        check("bus_en halt", 32'(BUS_EN), 0);
        check("xtal_en halt", 32'(XTAL_EN), 0);
        repeat (3) @(posedge CLK);
        check("still halted", 32'(HALTED), 1);
        irq_cmd <= (mode == 0);
        brk_cmd <= (mode == 1);
        evt     <= (mode == 2) ? 4'h8 : 4'h0;
        @(posedge CLK);
        irq_cmd <= 1'b0;
        brk_cmd <= 1'b0;
        evt     <= 4'h0;
        for (n = 0; n < 20 && XTAL_EN !== 1'b1; n++) @(posedge CLK);
        if (n >= 20) timeout("wake");
        check("halted woken", 32'(HALTED), 0);
        bus_at = -1;
        exc_at = -1;
        for (n = 0; n < len + 10 && exc_at < 0; n++) begin
            if (BUS_EN === 1'b1 && bus_at < 0) bus_at = n;
            if (EXC_START === 1'b1) exc_at = n;
            @(posedge CLK);
        end
        check("bus_en delay", bus_at, len - 1);
        check("exc delay", exc_at, len);
        check("exc pulse", 32'(EXC_START), 0);
    endtask : halt_wake

    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end

    initial begin
        {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA} = '0;
        {WAIT_ACTIVE, BREAK_STATE, stop_cmd, irq_cmd, brk_cmd, canned, RST_B} = '0;
        WSTRB = 4'hF;
        evt = 4'h0;
        RESET_PIN_B = 1'b1;
        n_mismatch = 0;
        comparisons = 0;
        repeat (5) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        rd(SMR_OFS_RST_CAUSE, 32'h20, SMR_RESP_OKAY, "cause por");
        rd(SMR_OFS_RST_CAUSE, 32'h00, SMR_RESP_OKAY, "cause read");
        rd(SMR_OFS_BRK_EXIT, 32'h00, SMR_RESP_OKAY, "flag rst");
        rd(SMR_OFS_BRK_CLR, 32'h00, SMR_RESP_OKAY, "enable rst");
        rd(8'h0C, 32'h00, SMR_RESP_SLVERR, "unmapped");
        wr(8'h0C, 32'hFF, SMR_RESP_SLVERR);
        wr(SMR_OFS_RST_CAUSE, 32'h3F, SMR_RESP_OKAY);
        rd(SMR_OFS_RST_CAUSE, 32'h00, SMR_RESP_OKAY, "cause write");
        BREAK_STATE <= 1'b1;
        repeat (3) @(posedge CLK);
        check("clr_ok off", 32'(CLR_OK), 0);
        wr(SMR_OFS_BRK_CLR, 32'h01, SMR_RESP_OKAY);
        rd(SMR_OFS_BRK_CLR, 32'h01, SMR_RESP_OKAY, "enable");
        check("clr_ok on", 32'(CLR_OK), 1);
        wr(SMR_OFS_BRK_CLR, 32'h00, SMR_RESP_OKAY);
        repeat (2) @(posedge CLK);
        check("clr_ok off again", 32'(CLR_OK), 0);
        BREAK_STATE <= 1'b0;
        repeat (3) @(posedge CLK);
        check("clr_ok run", 32'(CLR_OK), 1);
        for (int i = 0; i < 4; i++) begin
            evt <= 4'(1 << i);
            @(posedge CLK);
            evt <= 4'h0;
            @(posedge CLK);
            rd(SMR_OFS_RST_CAUSE, 32'(1 << i), SMR_RESP_OKAY, "cause event");
        end
        evt <= 4'h8;
        @(posedge CLK);
        evt <= 4'h4;
        @(posedge CLK);
        evt <= 4'h0;
        @(posedge CLK);
        rd(SMR_OFS_RST_CAUSE, 32'h04, SMR_RESP_OKAY, "cause last");
        RESET_PIN_B <= 1'b0;
        repeat (6) @(posedge CLK);
        RESET_PIN_B <= 1'b1;
        @(posedge CLK);
        rd(SMR_OFS_RST_CAUSE, 32'h10, SMR_RESP_OKAY, "cause pin");
        halt_wake(0, 1'b0, LREC);
        rd(SMR_OFS_BRK_EXIT, 32'h00, SMR_RESP_OKAY, "flag irq");
        halt_wake(1, 1'b1, SREC);
        rd(SMR_OFS_BRK_EXIT, 32'h01, SMR_RESP_OKAY, "flag break");
        wr(SMR_OFS_BRK_EXIT, 32'h01, SMR_RESP_OKAY);
        rd(SMR_OFS_BRK_EXIT, 32'h01, SMR_RESP_OKAY, "flag write one");
        wr(SMR_OFS_BRK_EXIT, 32'h00, SMR_RESP_OKAY);
        rd(SMR_OFS_BRK_EXIT, 32'h00, SMR_RESP_OKAY, "flag write zero");
        WAIT_ACTIVE <= 1'b1;
        brk_cmd <= 1'b1;
        @(posedge CLK);
        brk_cmd <= 1'b0;
        repeat (3) @(posedge CLK);
        WAIT_ACTIVE <= 1'b0;
        rd(SMR_OFS_BRK_EXIT, 32'h01, SMR_RESP_OKAY, "flag wait");
        halt_wake(2, 1'b0, LREC);
        rd(SMR_OFS_BRK_EXIT, 32'h00, SMR_RESP_OKAY, "flag event");
        rd(SMR_OFS_RST_CAUSE, 32'h08, SMR_RESP_OKAY, "cause wake");
        wr(SMR_OFS_BRK_CLR, 32'h01, SMR_RESP_OKAY);
        RST_B <= 1'b0;
        repeat (2) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        rd(SMR_OFS_BRK_CLR, 32'h00, SMR_RESP_OKAY, "enable rst2");
        rd(SMR_OFS_RST_CAUSE, 32'h20, SMR_RESP_OKAY, "cause rst2");
        finish_test();
    end
endmodule : smr_top_tb_top
